// File: design/opc_osc_ctrl.sv
`timescale 1ns/1ps
// Operation
// R1: Switching status reads 1 while main clock changes, until new source stable.
// R2: Fast oscillator runs on request, or always in Active/Idle/Standby if run bit.
// R3: Fast oscillator output given to requester two oscillator cycles after request.
// R4: Frequency select bits 5:2 choose output frequency; reset code 0x3.
// R5: Bit 0 of fast control enables auto-trim against slow crystal.
// R6: Trim holds signed six-bit step offset, -32 to +31.
// R7: Trim bits 7:6 ignore writes and mirror bit 5.
// R8: Trim writes are ignored while auto-trim is enabled.
// R9: On auto-trim disable, latest auto result loads within 3 us plus 3 clocks.
// R10: PLL runs on request or in Active/Idle/Standby; ready two PLL cycles later. Code runs it in those modes only with run bit 7 set.
// R11: PLL control bit 6 selects reference, internal or external fast clock.
// R12: Multiplier field 0 disables PLL, 1 gives x2, 2 gives x3.
// R13: Internal slow oscillator runs on request, or in all modes with run bit.
// R14: Internal slow oscillator output ready four cycles after request.
// R15: Crystal runs on request in Active/Idle, or in all modes with run bit.
// R16: Crystal output delivered within three cycles after request once started.
// R17: Startup field picks 1k, 16k, 32k or 64k crystal start-up cycles.
// R18: Startup and source bits are read-only while enabled or stable.
// R19: Bit 2 picks crystal on two pins or clock on one pin.
// R20: Bit 1 enables low-power crystal operation.
// R21: Bit 0 enables crystal and takes over its pins.
// R22: Software avoids reserved frequency and multiplier codes.
// R23: Control registers other than trim write only after the unlock key.
module opc_osc_ctrl #(
    parameter int STARTUP_SCALE = 1
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic       clkEn,
    // Wishbone slave
    input  wire logic       wb_cyc_i,
    input  wire logic       wb_stb_i,
    input  wire logic       wb_we_i,
    input  wire logic [7:0] wb_adr_i,
    input  wire logic [3:0] wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic            wb_ack_o,
    output logic            wb_err_o,
    // System state and requests
    input  wire logic [1:0] sleepMode,
    input  wire logic       fastReq,
    input  wire logic       pllReq,
    input  wire logic       slowReq,
    input  wire logic       xtalReq,
    input  wire logic       mainSwitchReq,
    input  wire logic       newSourceStable,
    input  wire logic [5:0] autoTrimResult,
    // Oscillator ticks from the analog side
    input  wire logic       fastTick,
    input  wire logic       pllTick,
    input  wire logic       slowTick,
    input  wire logic       xtalTick,
    // Oscillator controls
    output logic            fastRun,
    output logic            fastReady,
    output logic [3:0]      fastFreqSelect,
    output logic            autoTrimEnable,
    output logic [5:0]      fastTrim,
    output logic            pllRun,
    output logic            pllReady,
    output logic            pllSource,
    output logic [1:0]      pllMultFactor,
    output logic            slowRun,
    output logic            slowReady,
    output logic            xtalRun,
    output logic            xtalReady,
    output logic            xtalStable,
    output logic            xtalClockMode,
    output logic            lowPowerCrystal,
    output logic            xtalPinOverride,
    output logic            mainClockSwitching
);

    logic [7:0] fastCtrl_ff, trim_ff, pllCtrl_ff, slowCtrl_ff, xtalCtrl_ff;
    logic [2:0] unlockCnt_ff;
    logic       autoPrev_ff;
    logic [8:0] trimLoadCnt_ff;
    logic       trimPending_ff;
    logic [2:0] fastSync_ff, pllSync_ff, slowSync_ff, xtalSync_ff;
    logic [2:0] fastCnt_ff, pllCnt_ff, slowCnt_ff, xtalCnt_ff;
    logic [16:0] startCnt_ff;
    logic       xtalStable_ff;
    logic       ackPend_ff;
    logic [31:0] rdData_ff;
    opc_pkg::opc_switch_t swState_ff;

    logic       access, wrLo, deepSleep, powerDown, mapped, unlocked;
    logic       fastEdge, pllEdge, slowEdge, xtalEdge;
    logic [7:0] wrByte;
    logic [7:0] rdByte;
    logic [16:0] startTarget;

    function automatic logic tickEdge(input logic [2:0] s);
        return s[1] & ~s[2];
    endfunction

    function automatic logic [7:0] mergeField(input logic [7:0] old, input logic [7:0] val,
                                              input logic [7:0] mask);
        return (old & ~mask) | (val & mask);
    endfunction

    assign access    = wb_cyc_i & wb_stb_i & ~ackPend_ff & clkEn;
    assign wrLo      = access & wb_we_i & wb_sel_i[0];
    assign wrByte    = wb_dat_i[7:0];
    assign deepSleep = (sleepMode == opc_pkg::MODE_STANDBY) | (sleepMode == opc_pkg::MODE_PDOWN);
    assign powerDown = (sleepMode == opc_pkg::MODE_PDOWN);
    assign unlocked  = (unlockCnt_ff != 3'h0);
    assign fastEdge  = tickEdge(fastSync_ff);
    assign pllEdge   = tickEdge(pllSync_ff);
    assign slowEdge  = tickEdge(slowSync_ff);
    assign xtalEdge  = tickEdge(xtalSync_ff);

    always_comb begin
        mapped = 1'b1;
        rdByte = 8'h00;
        case (wb_adr_i)
            opc_pkg::FAST_CTRL_OFS: rdByte = fastCtrl_ff;
            opc_pkg::FAST_TRIM_OFS: rdByte = {trim_ff[5], trim_ff[5], trim_ff[5:0]}; // see R7
            opc_pkg::PLL_CTRL_OFS:  rdByte = pllCtrl_ff;
            opc_pkg::SLOW_INT_OFS:  rdByte = slowCtrl_ff;
            opc_pkg::SLOW_XTAL_OFS: rdByte = xtalCtrl_ff;
            opc_pkg::STATUS_OFS:    rdByte = {4'h0, xtalStable_ff, 2'h0, mainClockSwitching};
            opc_pkg::PROTECT_OFS:   rdByte = {7'h00, unlocked};
            opc_pkg::AUTO_TRIM_OFS: rdByte = {2'h0, autoTrimResult};
            default:                mapped = 1'b0;
        endcase
    end

    // Bus answer
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ackPend_ff <= 1'b0;
            rdData_ff  <= 32'h0000_0000;
        end else if (clkEn) begin
            ackPend_ff <= access;
            if (access) begin
                rdData_ff <= {24'h00_0000, rdByte};
            end
        end
    end
    assign wb_ack_o = ackPend_ff & wb_cyc_i & wb_stb_i & mapped;
    assign wb_err_o = ackPend_ff & wb_cyc_i & wb_stb_i & ~mapped;
    assign wb_dat_o = rdData_ff;

    // Unlock window
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            unlockCnt_ff <= 3'h0;
        end else if (clkEn) begin
            if (wrLo && wb_adr_i == opc_pkg::PROTECT_OFS && wrByte == opc_pkg::UNLOCK_KEY) begin
                unlockCnt_ff <= 3'(opc_pkg::UNLOCK_CYCLES);
            end else if (unlocked) begin
                unlockCnt_ff <= unlockCnt_ff - 3'h1;
            end
        end
    end

    // Protected control registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fastCtrl_ff <= opc_pkg::FAST_CTRL_RST;
            pllCtrl_ff  <= opc_pkg::PLL_CTRL_RST;
            slowCtrl_ff <= opc_pkg::SLOW_INT_RST;
            xtalCtrl_ff <= opc_pkg::SLOW_XTAL_RST;
        end else if (clkEn && wrLo && unlocked) begin // see R23
            case (wb_adr_i)
                opc_pkg::FAST_CTRL_OFS: fastCtrl_ff <= mergeField(fastCtrl_ff, wrByte, opc_pkg::FAST_CTRL_MASK);
                opc_pkg::PLL_CTRL_OFS:  pllCtrl_ff  <= mergeField(pllCtrl_ff, wrByte, opc_pkg::PLL_CTRL_MASK);
                opc_pkg::SLOW_INT_OFS:  slowCtrl_ff <= mergeField(slowCtrl_ff, wrByte, opc_pkg::SLOW_INT_MASK);
                opc_pkg::SLOW_XTAL_OFS: begin
                    if (xtalCtrl_ff[opc_pkg::XTAL_EN_BIT] || xtalStable_ff) begin // see R18
                        xtalCtrl_ff <= mergeField(xtalCtrl_ff, wrByte,
                                                  opc_pkg::SLOW_XTAL_MASK & ~opc_pkg::XTAL_LOCK_MASK);
                    end else begin
                        xtalCtrl_ff <= mergeField(xtalCtrl_ff, wrByte, opc_pkg::SLOW_XTAL_MASK);
                    end
                end
                default: ;
            endcase
        end
    end

    // Manual trim and auto-trim hand-back
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            trim_ff        <= opc_pkg::FAST_TRIM_RST;
            autoPrev_ff    <= 1'b0;
            trimPending_ff <= 1'b0;
            trimLoadCnt_ff <= 9'h000;
        end else if (clkEn) begin
            autoPrev_ff <= autoTrimEnable;
            if (autoPrev_ff && !autoTrimEnable) begin
                trimPending_ff <= 1'b1;
                trimLoadCnt_ff <= 9'(opc_pkg::TRIM_LOAD_CYCLES - 2);
            end else if (trimPending_ff) begin
                if (trimLoadCnt_ff == 9'h000) begin
                    trimPending_ff <= 1'b0;
                    trim_ff        <= {2'h0, autoTrimResult}; // see R9
                end else begin
                    trimLoadCnt_ff <= trimLoadCnt_ff - 9'h001;
                end
            end else if (wrLo && wb_adr_i == opc_pkg::FAST_TRIM_OFS && !autoTrimEnable) begin // see R8
                trim_ff <= {2'h0, wrByte[5:0]}; // see R6
            end
        end
    end

    // Main clock switch status
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            swState_ff <= opc_pkg::SW_IDLE;
        end else if (clkEn) begin
            case (swState_ff)
                opc_pkg::SW_IDLE: if (mainSwitchReq) swState_ff <= opc_pkg::SW_WAIT;
                opc_pkg::SW_WAIT: if (newSourceStable) swState_ff <= opc_pkg::SW_DONE;
                opc_pkg::SW_DONE: swState_ff <= opc_pkg::SW_IDLE;
                default:          swState_ff <= opc_pkg::SW_IDLE;
            endcase
        end
    end
    assign mainClockSwitching = (swState_ff == opc_pkg::SW_WAIT); // see R1

    // Tick synchronisers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fastSync_ff <= 3'h0;
            pllSync_ff  <= 3'h0;
            slowSync_ff <= 3'h0;
            xtalSync_ff <= 3'h0;
        end else if (clkEn) begin
            fastSync_ff <= {fastSync_ff[1:0], fastTick};
            pllSync_ff  <= {pllSync_ff[1:0], pllTick};
            slowSync_ff <= {slowSync_ff[1:0], slowTick};
            xtalSync_ff <= {xtalSync_ff[1:0], xtalTick};
        end
    end

    // Run decisions
    assign fastRun = fastReq | (fastCtrl_ff[opc_pkg::RUN_STBY_BIT] & ~powerDown); // see R2
    assign pllRun  = (pllMultFactor != 2'h0)
                   & (pllReq | (pllCtrl_ff[opc_pkg::RUN_STBY_BIT] & ~powerDown)); // see R10 R12
    assign slowRun = slowReq | slowCtrl_ff[opc_pkg::RUN_STBY_BIT]; // see R13
    assign xtalRun = xtalCtrl_ff[opc_pkg::XTAL_EN_BIT]
                   & ((xtalReq & ~deepSleep) | xtalCtrl_ff[opc_pkg::RUN_STBY_BIT]); // see R15

    // Request-to-ready counters in oscillator cycles
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fastCnt_ff <= 3'h0;
            pllCnt_ff  <= 3'h0;
            slowCnt_ff <= 3'h0;
            xtalCnt_ff <= 3'h0;
        end else if (clkEn) begin
            if (!(fastReq && fastRun)) fastCnt_ff <= 3'h0;
            else if (fastEdge && fastCnt_ff < 3'(opc_pkg::FAST_READY_CYC)) fastCnt_ff <= fastCnt_ff + 3'h1; // see R3
            if (!(pllReq && pllRun)) pllCnt_ff <= 3'h0;
            else if (pllEdge && pllCnt_ff < 3'(opc_pkg::PLL_READY_CYC)) pllCnt_ff <= pllCnt_ff + 3'h1; // see R10
            if (!slowReq) slowCnt_ff <= 3'h0;
            else if (slowEdge && slowCnt_ff < 3'(opc_pkg::SLOW_READY_CYC)) slowCnt_ff <= slowCnt_ff + 3'h1; // see R14
            if (!(xtalReq && xtalRun && xtalStable_ff)) xtalCnt_ff <= 3'h0;
            else if (xtalEdge && xtalCnt_ff < 3'(opc_pkg::XTAL_READY_CYC)) xtalCnt_ff <= xtalCnt_ff + 3'h1; // see R16
        end
    end
    assign fastReady = (fastCnt_ff == 3'(opc_pkg::FAST_READY_CYC));
    assign pllReady  = (pllCnt_ff == 3'(opc_pkg::PLL_READY_CYC));
    assign slowReady = (slowCnt_ff == 3'(opc_pkg::SLOW_READY_CYC));
    assign xtalReady = (xtalCnt_ff == 3'(opc_pkg::XTAL_READY_CYC));

    // Crystal start-up count
    always_comb begin
        case (xtalCtrl_ff[opc_pkg::STARTUP_LO +: 2]) // see R17
            2'h0:    startTarget = 17'(opc_pkg::STARTUP_1K / STARTUP_SCALE);
            2'h1:    startTarget = 17'(opc_pkg::STARTUP_16K / STARTUP_SCALE);
            2'h2:    startTarget = 17'(opc_pkg::STARTUP_32K / STARTUP_SCALE);
            default: startTarget = 17'(opc_pkg::STARTUP_64K / STARTUP_SCALE);
        endcase
        if (xtalClockMode) begin
            startTarget = 17'h0_0001;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            startCnt_ff   <= 17'h0_0000;
            xtalStable_ff <= 1'b0;
        end else if (clkEn) begin
            if (!xtalRun) begin
                startCnt_ff   <= 17'h0_0000;
                xtalStable_ff <= 1'b0;
            end else if (!xtalStable_ff && xtalEdge) begin
                if (startCnt_ff + 17'h0_0001 >= startTarget) begin
                    xtalStable_ff <= 1'b1;
                end
                startCnt_ff <= startCnt_ff + 17'h0_0001;
            end
        end
    end

    // Control outputs
    assign fastFreqSelect  = fastCtrl_ff[opc_pkg::FREQ_LO +: 4]; // see R4 R22
    assign autoTrimEnable  = fastCtrl_ff[opc_pkg::AUTO_TRIM_BIT]; // see R5
    assign fastTrim        = trim_ff[5:0];
    assign pllSource       = pllCtrl_ff[opc_pkg::PLL_SRC_BIT]; // see R11
    assign pllMultFactor   = pllCtrl_ff[opc_pkg::MULT_LO +: 2]; // see R12
    assign xtalStable      = xtalStable_ff;
    assign xtalClockMode   = xtalCtrl_ff[opc_pkg::SRC_SEL_BIT]; // see R19
    assign lowPowerCrystal = xtalCtrl_ff[opc_pkg::LOW_PWR_BIT]; // see R20
    assign xtalPinOverride = xtalCtrl_ff[opc_pkg::XTAL_EN_BIT]; // see R21

endmodule

// File: design/opc_pkg.sv
package opc_pkg;
    // Register byte offsets
    localparam logic [7:0] FAST_CTRL_OFS  = 8'h08;
    localparam logic [7:0] FAST_TRIM_OFS  = 8'h09;
    localparam logic [7:0] PLL_CTRL_OFS   = 8'h10;
    localparam logic [7:0] SLOW_INT_OFS   = 8'h18;
    localparam logic [7:0] SLOW_XTAL_OFS  = 8'h1C;
    localparam logic [7:0] STATUS_OFS     = 8'h05;
    localparam logic [7:0] PROTECT_OFS    = 8'h30;
    localparam logic [7:0] AUTO_TRIM_OFS  = 8'h34;
    // Reset values
    localparam logic [7:0] FAST_CTRL_RST  = 8'h0C;
    localparam logic [7:0] FAST_TRIM_RST  = 8'h00;
    localparam logic [7:0] PLL_CTRL_RST   = 8'h00;
    localparam logic [7:0] SLOW_INT_RST   = 8'h00;
    localparam logic [7:0] SLOW_XTAL_RST  = 8'h00;
    // Field positions
    localparam int RUN_STBY_BIT  = 7;
    localparam int FREQ_LO       = 2;
    localparam int AUTO_TRIM_BIT = 0;
    localparam int TRIM_SIGN_BIT = 5;
    localparam int PLL_SRC_BIT   = 6;
    localparam int MULT_LO       = 0;
    localparam int STARTUP_LO    = 4;
    localparam int SRC_SEL_BIT   = 2;
    localparam int LOW_PWR_BIT   = 1;
    localparam int XTAL_EN_BIT   = 0;
    // Field masks of writable bits
    localparam logic [7:0] FAST_CTRL_MASK = 8'hBD;
    localparam logic [7:0] PLL_CTRL_MASK  = 8'hC3;
    localparam logic [7:0] SLOW_INT_MASK  = 8'h80;
    localparam logic [7:0] SLOW_XTAL_MASK = 8'hB7;
    localparam logic [7:0] XTAL_LOCK_MASK = 8'h34;
    localparam logic [7:0] UNLOCK_KEY     = 8'hD8;
    // Protection window after the key, in clocks
    localparam int UNLOCK_CYCLES = 4;
    // Timing
    localparam int CLOCK_MHZ          = 100;
    localparam int TRIM_LOAD_US       = 3;
    localparam int TRIM_LOAD_EXTRA    = 3;
    localparam int TRIM_LOAD_CYCLES   = TRIM_LOAD_US * CLOCK_MHZ + TRIM_LOAD_EXTRA;
    localparam int FAST_READY_CYC     = 2;
    localparam int PLL_READY_CYC      = 2;
    localparam int SLOW_READY_CYC     = 4;
    localparam int XTAL_READY_CYC     = 3;
    localparam int STARTUP_1K         = 1024;
    localparam int STARTUP_16K        = 16384;
    localparam int STARTUP_32K        = 32768;
    localparam int STARTUP_64K        = 65536;
    // Sleep modes
    typedef enum logic [1:0] {
        MODE_ACTIVE  = 2'h0,
        MODE_IDLE    = 2'h1,
        MODE_STANDBY = 2'h2,
        MODE_PDOWN   = 2'h3
    } opc_sleep_t;
    typedef enum logic [2:0] {
        SW_IDLE   = 3'b001,
        SW_WAIT   = 3'b010,
        SW_DONE   = 3'b100
    } opc_switch_t;
endpackage

// File: testbench/opc_osc_ctrl_props.sv
`timescale 1ns/1ps
module opc_osc_props (
    // Clock, reset and bus
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic        clkEn,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    // Oscillator side
    input wire logic [1:0]  sleepMode,
    input wire logic        fastReq,
    input wire logic        pllReq,
    input wire logic        mainSwitchReq,
    input wire logic        newSourceStable,
    input wire logic [5:0]  autoTrimResult,
    input wire logic        fastRun,
    input wire logic        fastReady,
    input wire logic        autoTrimEnable,
    input wire logic [5:0]  fastTrim,
    input wire logic        pllRun,
    input wire logic        pllReady,
    input wire logic [1:0]  pllMultFactor,
    input wire logic        xtalStable,
    input wire logic        xtalClockMode,
    input wire logic        xtalPinOverride,
    input wire logic        mainClockSwitching
);
    wire taken;
    wire wr;
    assign taken = wb_cyc_i && wb_stb_i && clkEn && !wb_ack_o && !wb_err_o;
    assign wr = taken && wb_we_i;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    chk_bus_answer: assert property (taken |=> (wb_ack_o || wb_err_o)) else $error("bus request not answered");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    chk_trim_read:
        assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h09 |-> wb_dat_o[7:0] == {{2{fastTrim[5]}}, fastTrim})
        else $error("trim readback not sign extended");
    chk_trim_lock:
        assert property (wr && wb_adr_i == 8'h09 && autoTrimEnable |=> $stable(fastTrim)) else $error("trim written while locked");
    chk_trim_load:
        assert property ($fell(autoTrimEnable) |-> ##[1:303] fastTrim == autoTrimResult) else $error("trim not loaded");
    chk_xtal_lock:
        assert property (wr && wb_adr_i == 8'h1C && (xtalPinOverride || xtalStable) |=> $stable(xtalClockMode))
        else $error("crystal source changed while locked");
    chk_pll_off: assert property (pllMultFactor == 2'h0 |-> !pllRun) else $error("pll runs while disabled");
    chk_fast_req: assert property (fastReq && sleepMode != 2'h3 |-> fastRun) else $error("fast osc not run");
    chk_fast_drop: assert property (!fastReq && clkEn |=> !fastReady) else $error("fast ready without request");
    chk_pll_drop: assert property (!pllReq && clkEn |=> !pllReady) else $error("pll ready without request");
    chk_switch_set:
        assert property ($rose(mainSwitchReq) && clkEn && !newSourceStable |=> mainClockSwitching)
        else $error("switching not flagged");
    chk_switch_end:
        assert property (mainClockSwitching && newSourceStable && !mainSwitchReq |-> ##[1:3] !mainClockSwitching)
        else $error("switching flag stuck");
endmodule
bind opc_osc_ctrl opc_osc_props i_props (.clock, .rst_b, .clkEn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_dat_o, .wb_ack_o, .wb_err_o, .sleepMode, .fastReq, .pllReq, .mainSwitchReq, .newSourceStable,
    .autoTrimResult, .fastRun, .fastReady, .autoTrimEnable, .fastTrim, .pllRun, .pllReady, .pllMultFactor,
    .xtalStable, .xtalClockMode, .xtalPinOverride, .mainClockSwitching);

// File: testbench/opc_osc_model.sv
`timescale 1ns/1ps
module opc_osc_model (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_b,
    // Run controls
    input  wire logic fastRun,
    input  wire logic pllRun,
    input  wire logic slowRun,
    input  wire logic xtalRun,
    // Oscillator outputs
    output logic      fastTick,
    output logic      pllTick,
    output logic      slowTick,
    output logic      xtalTick
);
    logic [3:0] divCnt_ff;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            divCnt_ff <= 4'h0;
        end else begin
            divCnt_ff <= divCnt_ff + 4'h1;
        end
    end
    // A stopped oscillator holds its output low
    assign fastTick = fastRun & divCnt_ff[1];
    assign pllTick  = pllRun & divCnt_ff[1];
    assign slowTick = slowRun & divCnt_ff[3];
    assign xtalTick = xtalRun & divCnt_ff[2];
endmodule

// File: testbench/opc_osc_ctrl_tb.sv
`timescale 1ns/1ps
module opc_osc_ctrl_tb;
    logic clock = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, err, errSeen;
    logic fastReq = 1'b0, pllReq = 1'b0, slowReq = 1'b0, xtalReq = 1'b0, swReq = 1'b0, srcOk = 1'b0;
    logic fTick, pTick, sTick, xTick, fRun, fRdy, aTrim, pRun, pRdy, pSrc, sRun, sRdy;
    logic xRun, xRdy, xStable, xMode, lowPwr, pinOvr, switching;
    logic [1:0]  sleepMode = 2'h0;
    logic [1:0]  mult;
    logic [3:0]  freqSel;
    logic [5:0]  trim;
    logic [5:0]  atRes = 6'h00;
    logic [7:0]  adr = 8'h00;
    logic [7:0]  q, d;
    logic [31:0] wdat = 32'h0, rdat;
    logic [31:0] seed = 32'h7ACE1584;
    int          err_count = 0, n_checks = 0, cycles = 0;
    always #5 clock = ~clock;
    opc_osc_ctrl #(.STARTUP_SCALE(64)) i_dut (.clock(clock), .rst_b(rst_b), .clkEn(1'b1), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .wb_err_o(err), .sleepMode(sleepMode), .fastReq(fastReq), .pllReq(pllReq),
        .slowReq(slowReq), .xtalReq(xtalReq), .mainSwitchReq(swReq), .newSourceStable(srcOk),
        .autoTrimResult(atRes), .fastTick(fTick), .pllTick(pTick), .slowTick(sTick), .xtalTick(xTick),
        .fastRun(fRun), .fastReady(fRdy), .fastFreqSelect(freqSel), .autoTrimEnable(aTrim), .fastTrim(trim),
        .pllRun(pRun), .pllReady(pRdy), .pllSource(pSrc), .pllMultFactor(mult), .slowRun(sRun),
        .slowReady(sRdy), .xtalRun(xRun), .xtalReady(xRdy), .xtalStable(xStable), .xtalClockMode(xMode),
        .lowPowerCrystal(lowPwr), .xtalPinOverride(pinOvr), .mainClockSwitching(switching));
    opc_osc_model i_model (.clock(clock), .rst_b(rst_b), .fastRun(fRun), .pllRun(pRun), .slowRun(sRun),
        .xtalRun(xRun), .fastTick(fTick), .pllTick(pTick), .slowTick(sTick), .xtalTick(xTick));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] sx(input logic [7:0] v);
        return {{2{v[5]}}, v[5:0]};
    endfunction
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            close_out();
        end
    end
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            err_count++;
            $display("mismatch at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, v};
        @(posedge clock);
        while (ack !== 1'b1 && err !== 1'b1) begin
            @(posedge clock);
        end
        q = rdat[7:0];
        errSeen = err;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        check({24'h0, q}, {24'h0, e});
    endtask
    task automatic pw(input logic [7:0] a, input logic [7:0] v);
        bus(1'b1, opc_pkg::PROTECT_OFS, opc_pkg::UNLOCK_KEY);
        bus(1'b1, a, v);
    endtask
    task automatic await(input int k);
        int n;
        logic s;
        n = 0;
        s = 1'b0;
        while (s !== 1'b1 && n < 2000) begin
            @(posedge clock);
            n++;
            case (k)
                0: s = fRdy;
                1: s = pRdy;
                2: s = sRdy;
                default: s = xRdy;
            endcase
        end
        check(s, 1'b1);
    endtask
    initial begin
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        rdchk(8'h08, 8'h0C);
        rdchk(8'h09, 8'h00);
        rdchk(8'h10, 8'h00);
        rdchk(8'h18, 8'h00);
        rdchk(8'h1C, 8'h00);
        bus(1'b1, 8'h08, 8'h14);
        rdchk(8'h08, 8'h0C);
        bus(1'b0, 8'h40, 8'h00);
        check(errSeen, 1'b1);
        $display("test reset done");
        for (int i = 0; i < 10; i++) begin
            seed = lfsr(seed);
            d = (seed[7:0] & 8'hC3) | {2'h0, i[3:0], 2'h0};
            if (i != 4) begin
                pw(8'h08, d);
                rdchk(8'h08, d & opc_pkg::FAST_CTRL_MASK);
                check(freqSel, i[3:0]);
                check(aTrim, d[0]);
            end
        end
        for (int m = 0; m < 3; m++) begin
            seed = lfsr(seed);
            d = (seed[7:0] & 8'hFC) | {6'h00, m[1:0]};
            pw(8'h10, d);
            rdchk(8'h10, d & opc_pkg::PLL_CTRL_MASK);
            check(pSrc, d[6]);
            check(mult, m[1:0]);
        end
        pw(8'h08, 8'h0C);
        repeat (310) @(posedge clock);
        fastReq <= 1'b1;
        pllReq <= 1'b1;
        await(0);
        await(1);
        fastReq <= 1'b0;
        pllReq <= 1'b0;
        $display("test fast and pll done");
        for (int t = 0; t < 4; t++) begin
            seed = lfsr(seed);
            d = (t == 0) ? 8'h20 : (t == 1) ? 8'h5F : seed[7:0];
            bus(1'b1, 8'h09, d);
            rdchk(8'h09, sx(d));
            check(trim, d[5:0]);
        end
        atRes <= d[5:0];
        pw(8'h08, 8'h0D);
        bus(1'b1, 8'h09, d ^ 8'h15);
        rdchk(8'h09, sx(d));
        atRes <= d[5:0] ^ 6'h2A;
        pw(8'h08, 8'h0C);
        repeat (opc_pkg::TRIM_LOAD_CYCLES) @(posedge clock);
        check(trim, d[5:0] ^ 6'h2A);
        $display("test trim done");
        pw(8'h18, 8'hFF);
        rdchk(8'h18, 8'h80);
        sleepMode <= 2'h3;
        repeat (2) @(posedge clock);
        check(sRun, 1'b1);
        check(sRdy, 1'b0);
        sleepMode <= 2'h0;
        slowReq <= 1'b1;
        await(2);
        pw(8'h1C, 8'hB6);
        rdchk(8'h1C, 8'hB6);
        check({xMode, lowPwr, pinOvr}, 3'h6);
        pw(8'h1C, 8'hB7);
        pw(8'h1C, 8'h83);
        rdchk(8'h1C, 8'hB7);
        check(pinOvr, 1'b1);
        xtalReq <= 1'b1;
        await(3);
        pw(8'h1C, 8'h01);
        sleepMode <= 2'h2;
        repeat (2) @(posedge clock);
        check(xRun, 1'b0);
        pw(8'h1C, 8'h00);
        pw(8'h1C, 8'h01);
        sleepMode <= 2'h0;
        repeat (100) @(posedge clock);
        check(xStable, 1'b0);
        await(3);
        check(xStable, 1'b1);
        $display("test slow clocks done");
        swReq <= 1'b1;
        bus(1'b0, opc_pkg::STATUS_OFS, 8'h00);
        check(q[0], 1'b1);
        swReq <= 1'b0;
        srcOk <= 1'b1;
        repeat (4) @(posedge clock);
        bus(1'b0, opc_pkg::STATUS_OFS, 8'h00);
        check(q[0], 1'b0);
        $display("test switch done");
        close_out();
    end
endmodule
